/* rtl/smbus_pkg.sv */
// Shared constants and decode helpers for the SMBus memory slave and its master
`default_nettype none
package smbus_pkg;
  localparam logic [4:0]  ADDR_UPPER    = 5'h0D;
  localparam logic [7:0]  RAM_LAST      = 8'hDF;
  localparam logic [7:0]  NV_HI_FIRST   = 8'hF8;
  localparam logic [7:0]  NV_HI_LAST    = 8'hFB;
  localparam logic [7:0]  CMD_ERASE     = 8'hFE;
  localparam logic [7:0]  UPDATE_CONFIG_CONTROL_OFF    = 8'h90;
  localparam int          ERASE_EN_BIT  = 2;
  localparam int          PAGE_LSB      = 5;
  localparam logic [7:0]  ERASED        = 8'hFF;
  localparam int          RAM_DEPTH     = 224;
  localparam int          NV_DEPTH      = 1024;
  localparam int          NV_AW         = 10;
  localparam int          PAGE_BYTES    = 32;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam int          CLK_MHZ       = 40;
  localparam int          ERASE_TIME_US = 20000;
  localparam int          PROG_TIME_US  = 250;
  localparam int          ERASE_CYCLES  = ERASE_TIME_US * CLK_MHZ;
  localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  localparam int          ERASE_W       = 20;
  localparam int          PROG_W        = 14;
  // Master bit timing in hclk cycles
  localparam logic [7:0]  SCL_HALF      = 8'h0A;
  localparam logic [7:0]  SDA_SETUP     = 8'h02;
  // Master register map and command fields
  localparam logic [7:0]  CMD_OFF       = 8'h00;
  localparam logic [7:0]  STATUS_OFF    = 8'h04;
  localparam int          CMD_W         = 13;
  localparam int          F_START       = 8;
  localparam int          F_STOP        = 9;
  localparam int          F_READ        = 10;
  localparam int          F_NACK        = 11;
  localparam int          F_BYTE        = 12;
  localparam int          S_BUSY        = 0;
  localparam int          S_NACK        = 1;
  localparam int          S_RX_LSB      = 8;

  function automatic logic is_ram(input logic [7:0] c);
    return c <= RAM_LAST;
  endfunction

  function automatic logic is_nv_hi(input logic [7:0] c);
    return (c >= NV_HI_FIRST) && (c <= NV_HI_LAST);
  endfunction
endpackage
`default_nettype wire

/* rtl/smbus_if.sv */
// Two-wire bus meeting point: open-drain enables of both ends resolve to line levels
`default_nettype none
interface smbus_if;
  logic scl;
  logic sda;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic scl_s_o;
  logic scl_s_oe;
  logic sda_s_o;
  logic sda_s_oe;

  // Wired-AND with pull-ups: any enabled low driver wins
  assign scl = (scl_m_oe ? scl_m_o : 1'b1) & (scl_s_oe ? scl_s_o : 1'b1);
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport master (input scl, input sda, output scl_m_o, output scl_m_oe,
                  output sda_m_o, output sda_m_oe);
  modport slave  (input scl, input sda, output scl_s_o, output scl_s_oe,
                  output sda_s_o, output sda_s_oe);
endinterface
`default_nettype wire

/* rtl/line_sync.sv */
// Two-flop synchroniser for both bus lines with edge, start and stop detection
`default_nettype none
module line_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic scl_pin,
  input  wire logic sda_pin,
  output logic      scl,
  output logic      sda,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen
);
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } sync_s;

  sync_s r, n;

  always_comb begin
    n    = r;
    n.s1 = {scl_pin, sda_pin};
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  // Reset to released lines so no false edge follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '1;
    end else begin
      r <= n;
    end
  end

  assign scl        = r.s2[1];
  assign sda        = r.s2[0];
  assign scl_rise   = r.s2[1] & ~r.s3[1];
  assign scl_fall   = ~r.s2[1] & r.s3[1];
  assign start_seen = r.s2[1] & r.s3[1] & ~r.s2[0] & r.s3[0];
  assign stop_seen  = r.s2[1] & r.s3[1] & r.s2[0] & ~r.s3[0];
endmodule
`default_nettype wire

/* rtl/smbus_mem_slave.sv */
// Slave end: SMBus protocol engine over volatile registers and paged nonvolatile memory
// Function
// - Start is SDA falling with SCL high; address then direction.
// - Matching address acknowledged low through ninth pulse.
// - Nine pulses per byte; SDA moves only with SCL low.
// - Unmatched device stays idle, never drives SDA.
// - First written byte is the command byte.
// - Master sets read address by prior write.
// - Master ends read with NACK then stop.
// - Decode RAM 0x00-0xDF and NV 0xF800-0xFBFF.
// - Program only erased bytes; erase whole 32-byte pages.
// - Erase needs enable bit 2 of 0x90.
// - Send-byte: address and command both acknowledged.
// - Send-byte in RAM range sets current address.
// - Command 0xFE erases the pointed nonvolatile page.
// - Erase starts on command byte, lasts 20 ms.
// - Busy erasing: every access gets NACK.
// - Write byte/word: every received byte acknowledged.
// - RAM command plus one data byte stores it.
// - NV high command plus byte sets pointer.
// - Erase page uses pointer bits five and up.
// - NV command plus two bytes programs second byte.
// - Address is 01101 plus two select pins.
// - Receive-byte returns byte at current location.
// - Programming takes 250 us; stretch SCL meanwhile.
//
// Our own choice: the AHB-Lite slave port.
`default_nettype none
module smbus_mem_slave #(
  parameter int ERASE_CYC = smbus_pkg::ERASE_CYCLES,
  parameter int PROG_CYC  = smbus_pkg::PROG_CYCLES
) (
  smbus_if.slave    bus,
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic addr_select_hi_pin,
  input  wire logic addr_select_lo_pin,
  output logic      nv_busy
);
  import smbus_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_MACK = 5'b10000
  } slave_e;

  typedef struct packed {
    slave_e               st;
    logic [3:0]           bit_cnt;
    logic [1:0]           byte_idx;
    logic [7:0]           sh;
    logic [7:0]           cmd;
    logic                 rw;
    logic                 sda_oe;
    logic                 scl_oe;
    logic                 sel_nv;
    logic [7:0]           ram_ptr;
    logic [15:0]          nv_ptr;
    logic [7:0]           upd_cfg;
    logic [ERASE_W-1:0]   erase_cnt;
    logic [PROG_W-1:0]    prog_cnt;
    logic                 prog_ack;
    logic [1:0]           pin_s1;
    logic [1:0]           pin_s2;
    logic                 ram_we;
    logic                 nv_we;
    logic                 erase_go;
    logic [15:0]          wr_addr;
    logic [7:0]           wr_data;
  } slave_s;

  slave_s     r, n;
  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] nv  [NV_DEPTH];
  logic [7:0] rd_byte;
  logic       l_scl;
  logic       l_sda;
  logic       l_rise;
  logic       l_fall;
  logic       l_start;
  logic       l_stop;

  line_sync u_sync (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .scl_pin    (bus.scl),
    .sda_pin    (bus.sda),
    .scl        (l_scl),
    .sda        (l_sda),
    .scl_rise   (l_rise),
    .scl_fall   (l_fall),
    .start_seen (l_start),
    .stop_seen  (l_stop)
  );

  // Byte at the current location, either space
  always_comb begin
    if (r.sel_nv) begin
      rd_byte = nv[r.nv_ptr[NV_AW-1:0]];
    end else if (r.ram_ptr == UPDATE_CONFIG_CONTROL_OFF) begin
      rd_byte = r.upd_cfg;
    end else begin
      rd_byte = ram[r.ram_ptr];
    end
  end

  always_comb begin
    n          = r;
    n.ram_we   = 1'b0;
    n.nv_we    = 1'b0;
    n.erase_go = 1'b0;
    n.pin_s1   = {addr_select_hi_pin, addr_select_lo_pin};
    n.pin_s2   = r.pin_s1;
    if (r.erase_cnt != '0) begin
      n.erase_cnt = r.erase_cnt - 1'b1;
    end
    if (r.prog_cnt != '0) begin
      n.prog_cnt = r.prog_cnt - 1'b1;
    end else begin
      n.scl_oe = 1'b0;
    end
    if (l_start) begin
      n.st       = ST_RX;
      n.bit_cnt  = '0;
      n.byte_idx = '0;
      n.sda_oe   = 1'b0;
      // One programming per transaction; a new start re-arms it
      n.prog_ack = 1'b0;
    end else if (l_stop) begin
      n.st     = ST_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      unique case (r.st)
        ST_IDLE: begin
          n.sda_oe = 1'b0;
        end
        ST_RX: begin
          if (l_rise && r.bit_cnt < BYTE_BITS) begin
            n.sh      = {r.sh[6:0], l_sda};
            n.bit_cnt = r.bit_cnt + 1'b1;
          end else if (l_fall && r.bit_cnt == BYTE_BITS) begin
            n.st     = ST_ACK;
            n.sda_oe = 1'b1;
            if (r.byte_idx != 2'd3) begin
              n.byte_idx = r.byte_idx + 1'b1;
            end
            if (r.byte_idx == 2'd0) begin
              n.rw = r.sh[0];
              // Busy erasing answers nothing, not even its own address
              if (r.sh[7:1] != {ADDR_UPPER, r.pin_s2} || r.erase_cnt != '0) begin
                n.st     = ST_IDLE;
                n.sda_oe = 1'b0;
              end
            end else if (r.byte_idx == 2'd1) begin
              n.cmd = r.sh;
              if (is_ram(r.sh)) begin
                n.ram_ptr = r.sh;
                n.sel_nv  = 1'b0;
              end else if (r.sh == CMD_ERASE && r.upd_cfg[ERASE_EN_BIT]) begin
                n.erase_go  = 1'b1;
                n.erase_cnt = ERASE_W'(ERASE_CYC);
                n.wr_addr   = {r.nv_ptr[15:PAGE_LSB], {PAGE_LSB{1'b0}}};
              end
            end else if (r.byte_idx == 2'd2) begin
              if (is_ram(r.cmd)) begin
                if (r.cmd == UPDATE_CONFIG_CONTROL_OFF) begin
                  n.upd_cfg = r.sh;
                end else begin
                  n.ram_we  = 1'b1;
                  n.wr_addr = {8'h00, r.cmd};
                  n.wr_data = r.sh;
                end
              end else if (is_nv_hi(r.cmd)) begin
                n.nv_ptr = {r.cmd, r.sh};
                n.sel_nv = 1'b1;
              end
            end else if (is_nv_hi(r.cmd) && r.byte_idx == 2'd3 && !r.prog_ack
                         && r.prog_cnt == '0) begin
              n.nv_we    = 1'b1;
              n.wr_addr  = r.nv_ptr;
              n.wr_data  = r.sh;
              n.prog_cnt = PROG_W'(PROG_CYC);
              n.prog_ack = 1'b1;
            end
            // Other commands fall through: acknowledged, nothing stored
          end
        end
        ST_ACK: begin
          if (l_fall) begin
            n.sda_oe  = 1'b0;
            n.bit_cnt = '0;
            // Hold SCL low until the byte is programmed
            if (r.prog_ack && r.prog_cnt != '0) begin
              n.scl_oe = 1'b1;
            end
            if (r.byte_idx == 2'd1 && r.rw) begin
              n.st     = ST_TX;
              n.sh     = rd_byte;
              n.sda_oe = ~rd_byte[7];
            end else begin
              n.st = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (l_fall) begin
            n.bit_cnt = r.bit_cnt + 1'b1;
            n.sh      = {r.sh[6:0], 1'b0};
            if (r.bit_cnt == BYTE_BITS - 1'b1) begin
              n.st     = ST_MACK;
              n.sda_oe = 1'b0;
            end else begin
              n.sda_oe = ~r.sh[6];
            end
          end
        end
        ST_MACK: begin
          if (l_rise && l_sda) begin
            n.st = ST_IDLE;
          end else if (l_fall) begin
            n.st      = ST_TX;
            n.sh      = rd_byte;
            n.sda_oe  = ~rd_byte[7];
            n.bit_cnt = '0;
          end
        end
        default: begin
          n.st     = ST_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r    <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= n;
    end
  end

  // Array contents are not reset; a page must be erased before first programming
  always_ff @(posedge hclk) begin
    if (r.ram_we) begin
      ram[r.wr_addr[7:0]] <= r.wr_data;
    end
    if (r.nv_we && nv[r.wr_addr[NV_AW-1:0]] == ERASED) begin
      nv[r.wr_addr[NV_AW-1:0]] <= r.wr_data;
    end
    if (r.erase_go) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        nv[{r.wr_addr[NV_AW-1:PAGE_LSB], PAGE_LSB'(i)}] <= ERASED;
      end
    end
  end

  assign nv_busy      = (r.erase_cnt != '0) || (r.prog_cnt != '0);
  assign bus.scl_s_o  = 1'b0;
  assign bus.scl_s_oe = r.scl_oe;
  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = r.sda_oe;
endmodule
`default_nettype wire

/* rtl/smbus_host_ctrl.sv */
// Master end: AHB-Lite programmed byte engine that drives start, bytes and stop
`default_nettype none
module smbus_host_ctrl (
  smbus_if.master     bus,
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);
  import smbus_pkg::*;

  typedef enum logic [4:0] {
    H_IDLE  = 5'b00001,
    H_START = 5'b00010,
    H_LOW   = 5'b00100,
    H_HIGH  = 5'b01000,
    H_STOP  = 5'b10000
  } host_e;

  typedef struct packed {
    host_e            st;
    logic [1:0]       ph;
    logic [7:0]       cnt;
    logic [3:0]       bit_cnt;
    logic [7:0]       tx;
    logic [7:0]       rx;
    logic [CMD_W-1:0] cmd;
    logic             nack;
    logic             sda_oe;
    logic             scl_oe;
    logic             a_wr;
    logic [7:0]       a_off;
    logic [31:0]      rdata;
  } host_s;

  host_s r, n;
  logic  l_scl;
  logic  l_sda;
  logic  go;

  line_sync u_sync (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .scl_pin    (bus.scl),
    .sda_pin    (bus.sda),
    .scl        (l_scl),
    .sda        (l_sda),
    .scl_rise   (),
    .scl_fall   (),
    .start_seen (),
    .stop_seen  ()
  );

  // Commands written while busy are dropped
  assign go = r.a_wr && r.a_off == CMD_OFF && r.st == H_IDLE;

  always_comb begin
    n      = r;
    n.a_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.a_wr  = hwrite;
      n.a_off = haddr[7:0];
      n.rdata = '0;
      if (haddr[7:0] == CMD_OFF) begin
        n.rdata[CMD_W-1:0] = r.cmd;
      end else if (haddr[7:0] == STATUS_OFF) begin
        n.rdata[S_BUSY]             = (r.st != H_IDLE) || go;
        n.rdata[S_NACK]             = r.nack;
        n.rdata[S_RX_LSB +: 8]      = r.rx;
      end
    end
    unique case (r.st)
      H_IDLE: begin
        if (go) begin
          n.cmd     = hwdata[CMD_W-1:0];
          n.tx      = hwdata[7:0];
          n.cnt     = '0;
          n.ph      = '0;
          n.bit_cnt = '0;
          if (hwdata[F_START]) begin
            n.st = H_START;
          end else if (hwdata[F_BYTE]) begin
            n.st = H_LOW;
          end else if (hwdata[F_STOP]) begin
            n.st = H_STOP;
          end
        end
      end
      H_START: begin
        // Release both lines first so a repeated start also works
        if (r.ph == 2'd0) begin
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b0;
          if (l_scl) begin
            n.cnt = r.cnt + 1'b1;
          end
          if (r.cnt == SCL_HALF) begin
            n.sda_oe = 1'b1;
            n.ph     = 2'd1;
            n.cnt    = '0;
          end
        end else begin
          n.cnt = r.cnt + 1'b1;
          if (r.cnt == SCL_HALF) begin
            n.scl_oe = 1'b1;
            n.cnt    = '0;
            n.ph     = '0;
            n.st     = r.cmd[F_BYTE] ? H_LOW : (r.cmd[F_STOP] ? H_STOP : H_IDLE);
          end
        end
      end
      H_LOW: begin
        n.cnt = r.cnt + 1'b1;
        if (r.cnt == SDA_SETUP) begin
          if (r.bit_cnt < BYTE_BITS) begin
            n.sda_oe = !r.cmd[F_READ] && !r.tx[7];
          end else begin
            n.sda_oe = r.cmd[F_READ] && !r.cmd[F_NACK];
          end
        end
        if (r.cnt == SCL_HALF) begin
          n.scl_oe = 1'b0;
          n.cnt    = '0;
          n.st     = H_HIGH;
        end
      end
      H_HIGH: begin
        // Count only once SCL is really high: honours the slave's stretch
        if (l_scl) begin
          n.cnt = r.cnt + 1'b1;
        end
        if (r.cnt == SCL_HALF) begin
          n.scl_oe = 1'b1;
          n.cnt    = '0;
          if (r.bit_cnt < BYTE_BITS) begin
            n.rx      = {r.rx[6:0], l_sda};
            n.tx      = {r.tx[6:0], 1'b0};
            n.bit_cnt = r.bit_cnt + 1'b1;
            n.st      = H_LOW;
          end else begin
            n.nack    = l_sda;
            n.bit_cnt = '0;
            n.st      = r.cmd[F_STOP] ? H_STOP : H_IDLE;
          end
        end
      end
      H_STOP: begin
        n.cnt = r.cnt + 1'b1;
        if (r.ph == 2'd0) begin
          if (r.cnt == SDA_SETUP) begin
            n.sda_oe = 1'b1;
          end
          if (r.cnt == SCL_HALF) begin
            n.scl_oe = 1'b0;
            n.cnt    = '0;
            n.ph     = 2'd1;
          end
        end else if (r.ph == 2'd1) begin
          n.cnt = l_scl ? r.cnt + 1'b1 : r.cnt;
          if (r.cnt == SCL_HALF) begin
            n.sda_oe = 1'b0;
            n.cnt    = '0;
            n.ph     = 2'd2;
          end
        end else if (r.cnt == SCL_HALF) begin
          n.ph = '0;
          n.st = H_IDLE;
        end
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r    <= '0;
      r.st <= H_IDLE;
    end else begin
      r <= n;
    end
  end

  assign hrdata       = r.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = r.scl_oe;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = r.sda_oe;
endmodule
`default_nettype wire

/* tb/smbus_link_checker.sv */
// Protocol assertions on the shared two-wire bus
`default_nettype none
module smbus_link_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic scl_s_o,
  input wire logic scl_s_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bench programming time is 50 cycles; leave room for one clock low phase
  localparam int STRETCH_MAX = 120;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_start;
    $fell(sda) && scl;
  endsequence
  sequence s_stop;
    $rose(sda) && scl;
  endsequence
  chk_start_clock: assert property (s_start |-> ##[1:40] !scl)
    else $error("no clock after start");
  chk_ack_held: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe [*8])
    else $error("slave low bit not held in high phase");
  chk_sda_in_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave moved data while clock high");
  chk_scl_high_len: assert property ($fell(scl_m_oe) |-> !scl_m_oe [*8])
    else $error("clock high phase too short");
  chk_open_drain: assert property (!scl_s_o && !sda_s_o && !scl_m_o && !sda_m_o)
    else $error("a driver drives high");
  chk_stop_idle: assert property (s_stop |=> !sda_s_oe [*8])
    else $error("slave drives data after stop");
  chk_stretch_low: assert property ($rose(scl_s_oe) |-> !$past(scl))
    else $error("stretch began in clock high");
  chk_stretch_len: assert property ($rose(scl_s_oe) |-> ##[1:STRETCH_MAX] !scl_s_oe)
    else $error("stretch too long");
endmodule
`default_nettype wire

/* tb/test_smbus_ram_eeprom_slave.sv */
// Bench: host controller and memory slave on one bus, checked against a model
`default_nettype none
module test_smbus_ram_eeprom_slave;
  timeunit 1ns;
  timeprecision 1ps;
  import smbus_pkg::*;
  // Short erase keeps the run small but still outlasts one address byte
  localparam int ERASE_SIM = 2000;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, a_hi, a_lo, nv_busy;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  ram_m[int], nv_m[int];
  int          failures, checks, seed, rp, np, sel_nv;
  smbus_if sb ();
  smbus_mem_slave #(.ERASE_CYC(ERASE_SIM), .PROG_CYC(50)) i_smbus_mem_slave (
    .bus(sb), .hclk(hclk), .hresetn(hresetn), .addr_select_hi_pin(a_hi),
    .addr_select_lo_pin(a_lo), .nv_busy(nv_busy));
  smbus_host_ctrl i_smbus_host_ctrl (
    .bus(sb), .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
  smbus_link_checker i_smbus_link_checker (
    .hclk(hclk), .hresetn(hresetn), .scl(sb.scl), .sda(sb.sda), .scl_m_o(sb.scl_m_o),
    .scl_m_oe(sb.scl_m_oe), .sda_m_o(sb.sda_m_o), .sda_m_oe(sb.sda_m_oe),
    .scl_s_o(sb.scl_s_o), .scl_s_oe(sb.scl_s_oe), .sda_s_o(sb.sda_s_o),
    .sda_s_oe(sb.sda_s_oe));

  task automatic summarize;
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    failures++;
    $display("MISMATCH %s expected done seen timeout", nm);
    summarize();
  endtask

  task automatic hwt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) hang("hready");
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hwt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwt();
    q = hrdata;
    cmp("hresp", 32'h0, {31'h0, hresp});
  endtask

  // One engine command, then poll until the byte is on the wire and done
  task automatic xf(input logic [12:0] c, output logic [31:0] s);
    int n;
    ahb(1'b1, CMD_OFF, {19'h0, c}, s);
    n = 0;
    do begin
      ahb(1'b0, STATUS_OFF, 32'h0, s);
      n++;
    end while (s[S_BUSY] !== 1'b0 && n < 400);
    if (s[S_BUSY] !== 1'b0) hang("busy");
  endtask

  function automatic logic [7:0] sa(input logic r);
    return {ADDR_UPPER, a_hi, a_lo, r};
  endfunction

  task automatic wr(input logic [7:0] b[$], input logic nk);
    logic [31:0] s;
    foreach (b[i]) begin
      xf({3'h4, i == b.size() - 1, i == 0, b[i]}, s);
      cmp("ack", {31'h0, nk}, {31'h0, s[S_NACK]});
    end
  endtask

  task automatic put(input logic [7:0] c, input int n, input logic [7:0] d1, d2);
    logic [7:0] q[$];
    q = '{sa(1'b0), c};
    if (n > 0) q.push_back(d1);
    if (n > 1) q.push_back(d2);
    wr(q, 1'b0);
    if (c <= RAM_LAST) begin
      rp = c;
      sel_nv = 0;
      if (n > 0) ram_m[c] = d1;
    end else if (c >= NV_HI_FIRST && c <= NV_HI_LAST) begin
      np = {c[1:0], d1};
      sel_nv = 1;
      if (n > 1 && nv_m.exists(np) && nv_m[np] === ERASED) nv_m[np] = d2;
    end else if (c == CMD_ERASE && ram_m[UPDATE_CONFIG_CONTROL_OFF][ERASE_EN_BIT]) begin
      for (int k = 0; k < PAGE_BYTES; k++)
        nv_m[np / PAGE_BYTES * PAGE_BYTES + k] = ERASED;
    end
  endtask

  task automatic rd(input string nm);
    logic [31:0] s;
    logic [7:0]  e;
    xf({5'h11, sa(1'b1)}, s);
    cmp("ack", 32'h0, {31'h0, s[S_NACK]});
    e = sel_nv ? nv_m[np] : ram_m[rp];
    // First byte acknowledged by the host, so the slave sends the same byte again
    xf({5'h14, 8'h00}, s);
    cmp(nm, {24'h0, e}, {24'h0, s[S_RX_LSB +: 8]});
    xf({5'h1E, 8'h00}, s);
    cmp("end_nack", 32'h1, {31'h0, s[S_NACK]});
    cmp(nm, {24'h0, e}, {24'h0, s[S_RX_LSB +: 8]});
  endtask

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    logic [31:0] s;
    logic [7:0]  c, d;
    int          n;
    seed = 79982;
    failures = 0;
    checks = 0;
    {hresetn, hsel, hwrite, a_hi, a_lo} = 5'h00;
    {htrans, hsize, haddr, hwdata} = {2'h0, 3'h2, 64'h0};
    ram_m[UPDATE_CONFIG_CONTROL_OFF] = 8'h00;
    {rp, np, sel_nv} = 96'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h08, 32'h0, s);
    cmp("unmapped", 32'h0, s);
    put(UPDATE_CONFIG_CONTROL_OFF, 0, 8'h00, 8'h00);
    rd("cfg_reset");
    for (int k = 0; k < 4; k++) begin
      {a_hi, a_lo} <= k[1:0];
      repeat (4) @(posedge hclk);
      d = 8'($random(seed));
      c = (k == 0) ? 8'h00 : (k == 3) ? RAM_LAST : 8'($random(seed)) & 8'h7F;
      put(c, 1, d, 8'h00);
      put(c, 0, 8'h00, 8'h00);
      rd("ram");
      wr('{{ADDR_UPPER, ~a_hi, a_lo, 1'b0}, c, ~d}, 1'b1);
      put(8'hFC, 1, ~d, 8'h00);
      rd("ram_keep");
    end
    put(UPDATE_CONFIG_CONTROL_OFF, 1, 8'h04, 8'h00);
    put(8'hF9, 1, 8'h47, 8'h00);
    put(CMD_ERASE, 0, 8'h00, 8'h00);
    wr('{sa(1'b0)}, 1'b1);
    cmp("nv_busy", 32'h1, {31'h0, nv_busy});
    n = 0;
    while (nv_busy !== 1'b0 && n < ERASE_SIM) begin
      @(posedge hclk);
      n++;
    end
    if (nv_busy !== 1'b0) hang("erase");
    rd("erased");
    // Bit 7 clear keeps the programmed byte apart from the erased value
    d = 8'($random(seed)) & 8'h7F;
    put(8'hF9, 2, 8'h47, d);
    rd("prog");
    put(8'hF9, 2, 8'h47, ~d);
    rd("reprog");
    put(8'hF9, 1, 8'h5F, 8'h00);
    rd("page_end");
    put(UPDATE_CONFIG_CONTROL_OFF, 1, 8'h00, 8'h00);
    put(8'hF9, 1, 8'h47, 8'h00);
    put(CMD_ERASE, 0, 8'h00, 8'h00);
    rd("no_erase");
    summarize();
  end
endmodule
`default_nettype wire
